// *** bench/host_twi_model.sv ***
// host side of the two-wire management bus: start, stop, byte transfers
// assumes the bench resolves both lines from all enables and pull-ups
`timescale 1ns/1ps
`default_nettype none
module host_twi_model (
	// resolved data line
	input  wire logic sda_wire,
	// open-drain enables, low pulls the line down
	output var  logic scl_oe_b,
	output var  logic sda_oe_b
);
	localparam realtime Q = 31.25;
	int         rd_count;
	int         nack_count;
	logic [7:0] rd_last;
	logic       last_ack;

	initial begin
		scl_oe_b   = 1'b1;
		sda_oe_b   = 1'b1;
		rd_count   = 0;
		nack_count = 0;
	end

	// one bit, entered just after scl falls; lines only ever pulled low
	task automatic bit_io(input logic o, output logic i);
		#Q sda_oe_b = o;
		#Q scl_oe_b = 1'b1;
		#Q i = sda_wire;
		#Q scl_oe_b = 1'b0;
	endtask

	// also serves as repeated start
	task automatic start();
		#Q sda_oe_b = 1'b1;
		#Q scl_oe_b = 1'b1;
		#Q sda_oe_b = 1'b0;
		#Q scl_oe_b = 1'b0;
	endtask

	// clock stands released and high afterwards
	task automatic stop();
		#Q sda_oe_b = 1'b0;
		#Q scl_oe_b = 1'b1;
		#Q sda_oe_b = 1'b1;
		#Q;
	endtask

	task automatic wbyte(input logic [7:0] b);
		logic a;
		for (int k = 7; k >= 0; k--) begin
			bit_io(b[k], a);
		end
		bit_io(1'b1, a);
		last_ack = a;
		if (a) begin
			nack_count++;
		end
	endtask

	task automatic rbyte(input logic nack);
		logic [7:0] b;
		logic       a;
		for (int k = 7; k >= 0; k--) begin
			bit_io(1'b1, b[k]);
		end
		bit_io(nack, a);
		rd_last = b;
		rd_count++;
	endtask
endmodule
`default_nettype wire

// *** bench/testbench.sv ***
// self-checking bench for the sideband decode and paged memory block
// assumes the host model drives the bus; wired lines resolved here
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import mgmt_pkg::*;
	localparam int TMO = 40000;
	logic       core_clk;
	logic       rst_b;
	logic       module_reset_in;
	logic       module_lowpower_in;
	logic       irq_request;
	logic       host_scl_oe_b;
	logic       host_sda_oe_b;
	logic       scl_wire;
	logic       sda_wire;
	bus_pins_t  bus_pins;
	sideband_t  sideband;
	int         n_fail;
	int         check_count;
	int         cyc;
	int         seed;
	logic [7:0] exp_q[$];
	logic [7:0] dat[7];
	logic [7:0] pg[7] = '{PAGE_00, PAGE_01, PAGE_02, PAGE_10, PAGE_10, PAGE_11, PAGE_11};
	logic [7:0] bk[7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01};
	logic [7:0] off;
	logic [7:0] lo;

	// pull-ups on both lines
	assign scl_wire = host_scl_oe_b & (bus_pins.scl_oe_b | bus_pins.scl_out);
	assign sda_wire = host_sda_oe_b & (bus_pins.sda_oe_b | bus_pins.sda_out);

	mgmt_sideband_paging dut (
		.core_clk           (core_clk),
		.rst_b              (rst_b),
		.module_reset_in    (module_reset_in),
		.module_lowpower_in (module_lowpower_in),
		.irq_request        (irq_request),
		.scl_in             (scl_wire),
		.sda_in             (sda_wire),
		.bus_pins           (bus_pins),
		.sideband           (sideband)
	);

	host_twi_model host (
		.sda_wire (sda_wire),
		.scl_oe_b (host_scl_oe_b),
		.sda_oe_b (host_sda_oe_b)
	);

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	task automatic close_out();
		if (n_fail == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic cmp8(input string nm, input logic [7:0] e, input logic [7:0] s);
		check_count++;
		if (s !== e) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic cmp1(input string nm, input logic e, input logic s);
		check_count++;
		if (s !== e) begin
			n_fail++;
			$display("MISMATCH %s expected %b seen %b", nm, e, s);
		end
	endtask

	// frames start 2 ns after a falling edge, so no line moves on a rising edge
	task automatic wr(input logic [7:0] o, input logic [7:0] d);
		@(negedge core_clk);
		#2;
		host.start();
		host.wbyte({DEV_ADDR, 1'b0});
		host.wbyte(o);
		host.wbyte(d);
		host.stop();
	endtask

	// bank then page in one burst, offset auto-increments
	task automatic sel(input logic [7:0] b, input logic [7:0] p);
		@(negedge core_clk);
		#2;
		host.start();
		host.wbyte({DEV_ADDR, 1'b0});
		host.wbyte(BANK_SEL_ADDR);
		host.wbyte(b);
		host.wbyte(p);
		host.stop();
	endtask

	task automatic rd(input logic [7:0] o, input logic [7:0] e);
		exp_q.push_back(e);
		@(negedge core_clk);
		#2;
		host.start();
		host.wbyte({DEV_ADDR, 1'b0});
		host.wbyte(o);
		host.start();
		host.wbyte({DEV_ADDR, 1'b1});
		host.rbyte(1'b1);
		host.stop();
	endtask

	task automatic cycles(input int n);
		repeat (n) @(negedge core_clk);
	endtask

	// read bytes come back in issue order
	initial begin
		forever begin
			@(host.rd_count);
			cmp8("read data", exp_q.pop_front(), host.rd_last);
		end
	end

	always @(posedge core_clk) begin
		cyc++;
		if (cyc == TMO) begin
			n_fail++;
			close_out();
		end
	end

	initial begin
		seed = 32'h8A6B;
		n_fail = 0;
		check_count = 0;
		cyc = 0;
		rst_b = 1'b0;
		module_reset_in = 1'b1;
		module_lowpower_in = 1'b1;
		irq_request = 1'b0;
		cycles(16);
		cmp1("in_reset", 1'b1, sideband.in_reset);
		cmp1("present_pulldown", 1'b1, sideband.present_pulldown);
		cmp1("scl_oe_b", 1'b1, bus_pins.scl_oe_b);
		cmp1("sda_oe_b", 1'b1, bus_pins.sda_oe_b);
		cmp1("scl_out", 1'b0, bus_pins.scl_out);
		cmp1("sda_out", 1'b0, bus_pins.sda_out);
		rst_b = 1'b1;
		cycles(2);
		cmp1("in_reset", 1'b1, sideband.in_reset);
		cycles(1);
		cmp1("in_reset", 1'b0, sideband.in_reset);
		cmp1("irq_drive", 1'b0, sideband.irq_drive);
		irq_request = 1'b1;
		cycles(1);
		cmp1("irq_drive", 1'b1, sideband.irq_drive);
		irq_request = 1'b0;
		for (int i = 0; i < 6; i++) begin
			off = 8'($random(seed));
			module_lowpower_in = off[0];
			cycles(3);
			cmp1("lowpower_mode", ~off[0], sideband.lowpower_mode);
		end
		module_lowpower_in = 1'b1;
		// lower byte kept clear of the select bytes
		off = {1'b0, 7'($random(seed))} % BANK_SEL_ADDR;
		lo = 8'($random(seed));
		wr(off, lo);
		rd(off, lo);
		for (int i = 0; i < 7; i++) begin
			dat[i] = 8'($random(seed));
			sel(bk[i], pg[i]);
			wr(8'hFF, dat[i]);
		end
		for (int i = 0; i < 7; i++) begin
			sel(bk[i], pg[i]);
			cmp8("lane_base", (pg[i] >= LANE_PAGE_FIRST) ? bk[i] * LANES_PER_BANK : 8'h00,
				sideband.lane_base);
			rd(8'hFF, dat[i]);
		end
		sel(8'h02, PAGE_10);
		cmp8("lane_base", 8'h10, sideband.lane_base);
		rd(8'hFF, UNMAPPED_READ);
		sel(8'h00, 8'h05);
		rd(8'hFF, UNMAPPED_READ);
		rd(off, lo);
		// two-byte read: host acks the first byte, offset moves on
		wr(off + 8'h01, dat[1]);
		exp_q.push_back(lo);
		exp_q.push_back(dat[1]);
		@(negedge core_clk);
		#2;
		host.start();
		host.wbyte({DEV_ADDR, 1'b0});
		host.wbyte(off);
		host.start();
		host.wbyte({DEV_ADDR, 1'b1});
		host.rbyte(1'b0);
		host.rbyte(1'b1);
		host.stop();
		cmp1("all acked", 1'b1, host.nack_count == 0);
		// a foreign device address is left unacknowledged
		@(negedge core_clk);
		#2;
		host.start();
		host.wbyte({DEV_ADDR ^ 7'h01, 1'b0});
		host.stop();
		cmp1("foreign address nack", 1'b1, host.last_ack);
		sel(8'h01, PAGE_10);
		@(negedge core_clk);
		irq_request = 1'b1;
		module_reset_in = 1'b0;
		cycles(2);
		cmp1("in_reset", 1'b0, sideband.in_reset);
		cycles(1);
		cmp1("in_reset", 1'b1, sideband.in_reset);
		cmp1("irq_drive", 1'b0, sideband.irq_drive);
		cycles(4);
		cmp1("irq_drive", 1'b0, sideband.irq_drive);
		irq_request = 1'b0;
		module_reset_in = 1'b1;
		cycles(3);
		cmp1("in_reset", 1'b0, sideband.in_reset);
		cmp8("lane_base", 8'h00, sideband.lane_base);
		rd(8'hFF, dat[0]);
		cycles(10);
		close_out();
	end
endmodule
`default_nettype wire

// *** core/mgmt_sideband_paging.sv ***
// management side of a pluggable module: sideband decode and paged memory
// assumes sideband comparators and open-drain pads sit outside this block
// What this block does
// - low decoded reset input holds module in reset
// - interrupt request drives interrupt output high
// - lowest zone: in reset, interrupt deasserted
// - middle zone: running, interrupt deasserted
// - interrupt only asserted while out of reset
// - decoded low-power input is active low
// - presence shown by constant pull-down
// - low-power zone decoded puts module low-power
// - eight-bit byte offsets, 256 byte window
// - 00h-7Fh lower region, 80h-FFh selected page
// - lower 128 bytes always reachable
// - one 128-byte page mapped by page select
// - bank select picks instance of banked pages
// - lower region and page 00h implemented
// - pages 01h, 02h, 10h and 11h bank 0
// - lane pages: bank n covers lanes 8n upward
// - serial clock and data are open-drain only
`timescale 1ns/1ps
`default_nettype none
module mgmt_sideband_paging
	import mgmt_pkg::*;
(
	// clock and reset
	input  wire logic core_clk,
	input  wire logic rst_b,
	// decoded sideband comparator levels
	input  wire logic module_reset_in,
	input  wire logic module_lowpower_in,
	// event from module logic
	input  wire logic irq_request,
	// two-wire bus pins
	input  wire logic scl_in,
	input  wire logic sda_in,
	output var  bus_pins_t bus_pins,
	// sideband drive and status
	output var  sideband_t sideband
);

	mgmt_state_t st_reg;
	mgmt_state_t st_next;

	logic       scl_s;
	logic       sda_s;
	logic       mrst_s;
	logic       lp_s;
	logic       start_c;
	logic       stop_c;
	logic       rise_c;
	logic       fall_c;
	logic       wr_en;
	logic       hit_c;
	logic [2:0] slot_c;
	logic [9:0] mem_addr_c;
	logic [7:0] rd_byte_c;
	logic [7:0] byte_in;
	logic       sel_c;

	logic [7:0] mem [0:MEM_BYTES-1];

	// pins cross into the core clock
	pin_sync #(.STAGES(SYNC_STAGES), .RESET_VAL(1'b1)) u_sync_scl (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.d        (scl_in),
		.q        (scl_s)
	);
	pin_sync #(.STAGES(SYNC_STAGES), .RESET_VAL(1'b1)) u_sync_sda (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.d        (sda_in),
		.q        (sda_s)
	);
	pin_sync #(.STAGES(SYNC_STAGES), .RESET_VAL(1'b0)) u_sync_rst (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.d        (module_reset_in),
		.q        (mrst_s)
	);
	pin_sync #(.STAGES(SYNC_STAGES), .RESET_VAL(1'b0)) u_sync_lp (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.d        (module_lowpower_in),
		.q        (lp_s)
	);

	// bus conditions on the synchronised pins
	assign start_c = scl_s && st_reg.scl_d && st_reg.sda_d && !sda_s;
	assign stop_c  = scl_s && st_reg.scl_d && !st_reg.sda_d && sda_s;
	assign rise_c  = scl_s && !st_reg.scl_d;
	assign fall_c  = !scl_s && st_reg.scl_d;
	assign byte_in = {st_reg.shreg[6:0], sda_s};
	assign sel_c   = (st_reg.ptr == PAGE_SEL_ADDR) || (st_reg.ptr == BANK_SEL_ADDR);

	// address decode into memory slots
	always_comb begin
		hit_c  = 1'b1;
		slot_c = SLOT_LOWER;
		if (st_reg.ptr >= UPPER_FIRST) begin
			if (st_reg.page == PAGE_00) begin
				slot_c = SLOT_P00;
			end else if (st_reg.page == PAGE_01) begin
				slot_c = SLOT_P01;
			end else if (st_reg.page == PAGE_02) begin
				slot_c = SLOT_P02;
			end else if (st_reg.page == PAGE_10 && st_reg.bank < BANKS_IMPL) begin
				slot_c = SLOT_P10 + {2'b00, st_reg.bank[0]};
			end else if (st_reg.page == PAGE_11 && st_reg.bank < BANKS_IMPL) begin
				slot_c = SLOT_P11 + {2'b00, st_reg.bank[0]};
			end else begin
				hit_c = 1'b0;
			end
		end
		mem_addr_c = {slot_c, st_reg.ptr[6:0]};
		if (!hit_c) begin
			rd_byte_c = UNMAPPED_READ;
		end else if (st_reg.ptr == PAGE_SEL_ADDR) begin
			rd_byte_c = st_reg.page;
		end else if (st_reg.ptr == BANK_SEL_ADDR) begin
			rd_byte_c = st_reg.bank;
		end else begin
			rd_byte_c = mem[mem_addr_c];
		end
	end

	// next state of the whole block
	always_comb begin
		st_next       = st_reg;
		wr_en         = 1'b0;
		st_next.scl_d = scl_s;
		st_next.sda_d = sda_s;
		st_next.irq   = irq_request;
		st_next.run   = 1'b1;
		st_next.lowpower = !lp_s;
		if (st_reg.page >= LANE_PAGE_FIRST && st_reg.page <= LANE_PAGE_LAST) begin
			st_next.lane_base = 8'(st_reg.bank * LANES_PER_BANK);
		end else begin
			st_next.lane_base = 8'h00;
		end
		if (start_c) begin
			st_next.st      = ST_DEVADDR;
			st_next.bitcnt  = 3'h0;
			st_next.sda_drv = 1'b0;
			st_next.in_ack  = 1'b0;
		end else if (stop_c) begin
			st_next.st      = ST_IDLE;
			st_next.sda_drv = 1'b0;
			st_next.in_ack  = 1'b0;
		end else if (rise_c) begin
			unique case (st_reg.st)
				ST_IDLE, ST_ACK_DEV, ST_ACK_OFF, ST_ACK_WR: begin
				end
				ST_DEVADDR, ST_OFFSET, ST_WDATA: begin
					st_next.shreg  = byte_in;
					st_next.bitcnt = st_reg.bitcnt + 3'h1;
					if (st_reg.bitcnt == LAST_BIT) begin
						st_next.ack_ok = 1'b1;
						if (st_reg.st == ST_DEVADDR) begin
							st_next.st      = ST_ACK_DEV;
							st_next.ack_ok  = (byte_in[7:1] == DEV_ADDR);
							st_next.rd_mode = byte_in[0];
						end else if (st_reg.st == ST_OFFSET) begin
							st_next.st  = ST_ACK_OFF;
							st_next.ptr = byte_in;
						end else begin
							st_next.st  = ST_ACK_WR;
							st_next.ptr = st_reg.ptr + 8'h01;
							wr_en       = 1'b1;
							if (st_reg.ptr == PAGE_SEL_ADDR) begin
								st_next.page = byte_in;
							end
							if (st_reg.ptr == BANK_SEL_ADDR) begin
								st_next.bank = byte_in;
							end
						end
					end
				end
				ST_RDATA: begin
					st_next.bitcnt = st_reg.bitcnt + 3'h1;
					if (st_reg.bitcnt == LAST_BIT) begin
						st_next.st  = ST_ACK_RD;
						st_next.ptr = st_reg.ptr + 8'h01;
					end
				end
				ST_ACK_RD: begin
					st_next.ack_ok = !sda_s;
				end
			endcase
		end else if (fall_c) begin
			unique case (st_reg.st)
				ST_IDLE, ST_DEVADDR, ST_OFFSET, ST_WDATA: begin
				end
				ST_RDATA: begin
					st_next.shreg   = {st_reg.shreg[6:0], 1'b1};
					st_next.sda_drv = !st_reg.shreg[6];
				end
				ST_ACK_DEV, ST_ACK_OFF, ST_ACK_WR, ST_ACK_RD: begin
					if (!st_reg.in_ack) begin
						st_next.in_ack  = 1'b1;
						st_next.sda_drv = st_reg.ack_ok && (st_reg.st != ST_ACK_RD);
					end else begin
						st_next.in_ack  = 1'b0;
						st_next.sda_drv = 1'b0;
						st_next.bitcnt  = 3'h0;
						if (!st_reg.ack_ok) begin
							st_next.st = ST_IDLE;
						end else if (st_reg.st == ST_ACK_DEV && !st_reg.rd_mode) begin
							st_next.st = ST_OFFSET;
						end else if (st_reg.st == ST_ACK_DEV || st_reg.st == ST_ACK_RD) begin
							st_next.st      = ST_RDATA;
							st_next.shreg   = rd_byte_c;
							st_next.sda_drv = !rd_byte_c[7];
						end else begin
							st_next.st = ST_WDATA;
						end
					end
				end
			endcase
		end
		if (!mrst_s) begin
			st_next          = STATE_RESET;
			st_next.scl_d    = scl_s;
			st_next.sda_d    = sda_s;
			st_next.lowpower = !lp_s;
			wr_en            = 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_reg <= STATE_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	// selection bytes live in the state, not in the array
	always_ff @(posedge core_clk) begin
		if (wr_en && hit_c && !sel_c) begin
			mem[mem_addr_c] <= byte_in;
		end
	end

	// pads only ever pull low
	always_comb begin
		bus_pins.scl_out  = 1'b0;
		bus_pins.scl_oe_b = 1'b1;
		bus_pins.sda_out  = 1'b0;
		bus_pins.sda_oe_b = !st_reg.sda_drv;
	end

	always_comb begin
		sideband.irq_drive        = st_reg.irq && st_reg.run;
		sideband.lowpower_mode    = st_reg.lowpower;
		sideband.present_pulldown = 1'b1;
		sideband.in_reset         = !st_reg.run;
		sideband.lane_base        = st_reg.lane_base;
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	sequence s_dev_match;
		rise_c && st_reg.st == ST_DEVADDR && st_reg.bitcnt == LAST_BIT
			&& byte_in[7:1] == DEV_ADDR && mrst_s && !start_c && !stop_c;
	endsequence

	sequence s_offset_byte;
		rise_c && st_reg.st == ST_OFFSET && st_reg.bitcnt == LAST_BIT
			&& mrst_s && !start_c && !stop_c;
	endsequence

	sequence s_page_write;
		rise_c && st_reg.st == ST_WDATA && st_reg.bitcnt == LAST_BIT
			&& st_reg.ptr == PAGE_SEL_ADDR && mrst_s && !start_c && !stop_c;
	endsequence

	sequence s_bank_write;
		rise_c && st_reg.st == ST_WDATA && st_reg.bitcnt == LAST_BIT
			&& st_reg.ptr == BANK_SEL_ADDR && mrst_s && !start_c && !stop_c;
	endsequence

	property p_reset_holds;
		!mrst_s |=> sideband.in_reset && !sideband.irq_drive && st_reg.st == ST_IDLE;
	endproperty
	a_reset_holds: assert property (p_reset_holds) else $error("reset zone not held");

	property p_irq_follows;
		(irq_request && mrst_s) |=> sideband.irq_drive;
	endproperty
	a_irq_follows: assert property (p_irq_follows) else $error("interrupt not raised");

	property p_normal_zone;
		(mrst_s && !irq_request) |=> !sideband.in_reset && !sideband.irq_drive;
	endproperty
	a_normal_zone: assert property (p_normal_zone) else $error("normal zone wrong");

	property p_irq_gated;
		sideband.irq_drive |-> !sideband.in_reset && $past(mrst_s);
	endproperty
	a_irq_gated: assert property (p_irq_gated) else $error("interrupt while in reset");

	property p_lowpower;
		sideband.lowpower_mode == !$past(lp_s);
	endproperty
	a_lowpower: assert property (p_lowpower) else $error("low-power decode wrong");

	property p_present;
		sideband.present_pulldown;
	endproperty
	a_present: assert property (p_present) else $error("presence pull-down dropped");

	property p_offset_load;
		s_offset_byte |=> st_reg.ptr == $past(byte_in) && st_reg.st == ST_ACK_OFF;
	endproperty
	a_offset_load: assert property (p_offset_load) else $error("offset not loaded");

	property p_dev_ack;
		s_dev_match |=> st_reg.st == ST_ACK_DEV && st_reg.ack_ok;
	endproperty
	a_dev_ack: assert property (p_dev_ack) else $error("own address not acknowledged");

	property p_lower_always;
		(st_reg.ptr <= LOWER_LAST) |-> hit_c && slot_c == SLOT_LOWER;
	endproperty
	a_lower_always: assert property (p_lower_always) else $error("lower region not mapped");

	property p_page_write;
		s_page_write |=> st_reg.page == $past(byte_in);
	endproperty
	a_page_write: assert property (p_page_write) else $error("page select lost");

	property p_bank_write;
		s_bank_write |=> st_reg.bank == $past(byte_in);
	endproperty
	a_bank_write: assert property (p_bank_write) else $error("bank select lost");

	property p_bank_map;
		(st_reg.ptr >= UPPER_FIRST && st_reg.page == PAGE_10 && st_reg.bank == 8'h01)
			|-> hit_c && slot_c == 3'h5;
	endproperty
	a_bank_map: assert property (p_bank_map) else $error("bank 1 not mapped");

	property p_page00;
		(st_reg.ptr >= UPPER_FIRST && st_reg.page == PAGE_00) |-> hit_c && slot_c == SLOT_P00;
	endproperty
	a_page00: assert property (p_page00) else $error("page 00h not mapped");

	property p_paged_set;
		(st_reg.ptr >= UPPER_FIRST && st_reg.bank == 8'h00 && (st_reg.page == PAGE_01
			|| st_reg.page == PAGE_02 || st_reg.page == PAGE_11)) |-> hit_c;
	endproperty
	a_paged_set: assert property (p_paged_set) else $error("required page missing");

	property p_lane_base;
		(st_reg.page >= LANE_PAGE_FIRST && st_reg.page <= LANE_PAGE_LAST && mrst_s)
			|=> sideband.lane_base == 8'($past(st_reg.bank) * LANES_PER_BANK);
	endproperty
	a_lane_base: assert property (p_lane_base) else $error("lane group base wrong");

	property p_open_drain;
		!bus_pins.sda_out && bus_pins.scl_oe_b && (bus_pins.sda_oe_b
			|| st_reg.st inside {ST_ACK_DEV, ST_ACK_OFF, ST_ACK_WR, ST_RDATA, ST_ACK_RD});
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("bus pin driven high");

	property p_sel_reset;
		!mrst_s |=> st_reg.page == RESET_PAGE && st_reg.bank == RESET_BANK;
	endproperty
	a_sel_reset: assert property (p_sel_reset) else $error("selection not cleared");

endmodule
`default_nettype wire

// *** core/pin_sync.sv ***
// two flip-flop synchroniser for one level from outside the clock domain
// assumes rst_b is asynchronous, active low
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter int   STAGES    = 2,
	parameter logic RESET_VAL = 1'b0
) (
	// clock and reset
	input  wire logic core_clk,
	input  wire logic rst_b,
	// level in and out
	input  wire logic d,
	output logic      q
);

	logic [STAGES-1:0] sync_reg;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			sync_reg <= {STAGES{RESET_VAL}};
		end else begin
			sync_reg <= {sync_reg[STAGES-2:0], d};
		end
	end

	assign q = sync_reg[STAGES-1];

endmodule
`default_nettype wire

// *** inc/mgmt_pkg.sv ***
// constants, types and reset values for the module management block
// assumes a single core clock; pins arrive already decoded to logic levels
package mgmt_pkg;

	// synchroniser depth
	localparam int SYNC_STAGES = 2;

	// serial bus device address, value is arbitrary
	localparam logic [6:0] DEV_ADDR = 7'h50;

	// host address map
	localparam logic [7:0] LOWER_LAST    = 8'h7F;
	localparam logic [7:0] UPPER_FIRST   = 8'h80;
	localparam logic [7:0] BANK_SEL_ADDR = 8'h7E;
	localparam logic [7:0] PAGE_SEL_ADDR = 8'h7F;

	// implemented pages
	localparam logic [7:0] PAGE_00         = 8'h00;
	localparam logic [7:0] PAGE_01         = 8'h01;
	localparam logic [7:0] PAGE_02         = 8'h02;
	localparam logic [7:0] PAGE_10         = 8'h10;
	localparam logic [7:0] PAGE_11         = 8'h11;
	localparam logic [7:0] LANE_PAGE_FIRST = 8'h10;
	localparam logic [7:0] LANE_PAGE_LAST  = 8'h1F;
	localparam logic [7:0] BANKS_IMPL      = 8'h02;
	localparam logic [7:0] LANES_PER_BANK  = 8'h08;

	// reset values of selection and read of an unmapped byte
	localparam logic [7:0] RESET_PAGE    = 8'h00;
	localparam logic [7:0] RESET_BANK    = 8'h00;
	localparam logic [7:0] UNMAPPED_READ = 8'hFF;

	// memory slots of 128 bytes each
	localparam logic [2:0] SLOT_LOWER = 3'h0;
	localparam logic [2:0] SLOT_P00   = 3'h1;
	localparam logic [2:0] SLOT_P01   = 3'h2;
	localparam logic [2:0] SLOT_P02   = 3'h3;
	localparam logic [2:0] SLOT_P10   = 3'h4;
	localparam logic [2:0] SLOT_P11   = 3'h6;
	localparam int         MEM_BYTES  = 1024;
	localparam logic [2:0] LAST_BIT   = 3'h7;

	typedef enum logic [3:0] {
		ST_IDLE, ST_DEVADDR, ST_ACK_DEV, ST_OFFSET, ST_ACK_OFF,
		ST_WDATA, ST_ACK_WR, ST_RDATA, ST_ACK_RD
	} bus_state_t;

	typedef struct packed {
		logic scl_out;
		logic scl_oe_b;
		logic sda_out;
		logic sda_oe_b;
	} bus_pins_t;

	typedef struct packed {
		logic       irq_drive;
		logic       lowpower_mode;
		logic       present_pulldown;
		logic       in_reset;
		logic [7:0] lane_base;
	} sideband_t;

	typedef struct packed {
		bus_state_t st;
		logic [2:0] bitcnt;
		logic [7:0] shreg;
		logic [7:0] ptr;
		logic [7:0] page;
		logic [7:0] bank;
		logic       rd_mode;
		logic       ack_ok;
		logic       in_ack;
		logic       sda_drv;
		logic       scl_d;
		logic       sda_d;
		logic       irq;
		logic       lowpower;
		logic       run;
		logic [7:0] lane_base;
	} mgmt_state_t;

	localparam mgmt_state_t STATE_RESET = '{
		st: ST_IDLE, bitcnt: 3'h0, shreg: 8'h00, ptr: 8'h00,
		page: RESET_PAGE, bank: RESET_BANK, rd_mode: 1'b0, ack_ok: 1'b0,
		in_ack: 1'b0, sda_drv: 1'b0, scl_d: 1'b1, sda_d: 1'b1, irq: 1'b0,
		lowpower: 1'b1, run: 1'b0, lane_base: 8'h00
	};

endpackage
